// ### verilog/rtc_pkg.sv
// constants, field layout and record type of the second tick calendar clock
package rtc_pkg;

	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TB_HZ = 32768;
	localparam int ACC_W = 24;
	localparam int FRAC_W = 15;
	localparam logic [14:0] FRAC_MAX = 15'h7FFF;

	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CMD = 5'h04;
	localparam logic [4:0] OFS_SUBSEC = 5'h08;
	localparam logic [4:0] OFS_TIME = 5'h0C;
	localparam logic [4:0] OFS_DATE = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;
	localparam logic [4:0] OFS_MASK = 5'h18;

	// settings_flag_word bits
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PUSH_BIT = 1;
	localparam int CTRL_LINK_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h7;

	// command bits, write one to act
	localparam int CMD_SUSPEND_BIT = 0;
	localparam int CMD_RESUME_BIT = 1;
	localparam int CMD_CLEAR_BIT = 2;

	// interrupt status and mask bits
	localparam int IRQ_W = 2;
	localparam int IRQ_TICK_BIT = 0;
	localparam int IRQ_REMOTE_BIT = 1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	// field positions in the time word
	localparam int TW_SEC = 0;
	localparam int TW_MIN = 8;
	localparam int TW_HOUR = 16;
	localparam int TW_DOW = 24;
	// field positions in the date word
	localparam int DW_DATE = 0;
	localparam int DW_MONTH = 8;
	localparam int DW_YEAR = 16;

	localparam logic [2:0] DOW_SAT = 3'h6;
	localparam logic [2:0] DOW_UNKNOWN = 3'h7;

	typedef struct packed {
		logic [15:0] year;
		logic [3:0] month;
		logic [4:0] date;
		logic [2:0] dow;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} time_s;

	localparam time_s TIME_RESET = '{year: 16'h0000, month: 4'h1, date: 5'h01,
		dow: 3'h7, hour: 5'h00, min: 6'h00, sec: 6'h00};

endpackage

// ### verilog/second_tick_calendar_clock.sv
// calendar clock advanced once per second from a 32768 Hz time base
// How it works
// - time base only runs while the clock_enable_flag is set; software may clear it.
// - fraction counter steps at 32768 Hz and flags every elapsed second.
// - with enable clear, time stands and no second_tick_event is raised.
// - with enable clear, no keep-alive ping pulses are sent.
// - each second the time record updates first, then the tick event rises.
// - day of week sits in bits 24-26 of the time word, 0-6 Sunday-Saturday, 7 unknown.
// - subsecond_write loads the fraction count with a value 0 to 32767.
// - subsecond_read returns the current fraction count, 0 to 32767.
// - subsecond_clear zeroes the fraction, whole-second fields kept.
// - a linked user control is refreshed once every second.
// - the refreshed value is pushed to the client only with client_push_flag set.
// - a remote change of the linked control loads the time record.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

module second_tick_calendar_clock (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [4:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	output logic irq_o,
	output logic ping_o,
	output logic ui_refresh_o,
	output logic client_push_o,
	output rtc_pkg::time_s ui_value_o,
	input wire logic remote_set_i,
	input rtc_pkg::time_s remote_time_i
);

	typedef enum {
		ST_IDLE,
		ST_UPDATE,
		ST_SIGNAL
	} seq_e;

	localparam logic [23:0] TB_STEP = 24'(rtc_pkg::TB_HZ);
	localparam logic [23:0] TB_WRAP = 24'(rtc_pkg::CLK_HZ);

	function automatic logic is_leap(input logic [15:0] y);
		is_leap = (y[1:0] == 2'b00) &&
			(((y % 16'd100) != 16'd0) || ((y % 16'd400) == 16'd0));
	endfunction

	function automatic logic [4:0] days_in(input logic [3:0] m, input logic [15:0] y);
		case (m)
			4'h4, 4'h6, 4'h9, 4'hB: days_in = 5'd30;
			4'h2: days_in = is_leap(y) ? 5'd29 : 5'd28;
			default: days_in = 5'd31;
		endcase
	endfunction

	function automatic rtc_pkg::time_s next_time(input rtc_pkg::time_s c);
		rtc_pkg::time_s t;
		t = c;
		if (c.sec >= 6'd59) begin
			t.sec = 6'd0;
			if (c.min >= 6'd59) begin
				t.min = 6'd0;
				if (c.hour >= 5'd23) begin
					t.hour = 5'd0;
					if (c.dow != rtc_pkg::DOW_UNKNOWN) begin
						t.dow = (c.dow >= rtc_pkg::DOW_SAT) ? 3'd0 : c.dow + 3'd1;
					end
					if (c.date >= days_in(c.month, c.year)) begin
						t.date = 5'd1;
						if (c.month >= 4'd12) begin
							t.month = 4'd1;
							t.year = c.year + 16'd1;
						end else begin
							t.month = c.month + 4'd1;
						end
					end else begin
						t.date = c.date + 5'd1;
					end
				end else begin
					t.hour = c.hour + 5'd1;
				end
			end else begin
				t.min = c.min + 6'd1;
			end
		end else begin
			t.sec = c.sec + 6'd1;
		end
		next_time = t;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	function automatic logic [31:0] time_word(input rtc_pkg::time_s t);
		logic [31:0] w;
		w = 32'h00000000;
		w[rtc_pkg::TW_SEC +: 6] = t.sec;
		w[rtc_pkg::TW_MIN +: 6] = t.min;
		w[rtc_pkg::TW_HOUR +: 5] = t.hour;
		w[rtc_pkg::TW_DOW +: 3] = t.dow;
		time_word = w;
	endfunction

	function automatic logic [31:0] date_word(input rtc_pkg::time_s t);
		logic [31:0] w;
		w = 32'h00000000;
		w[rtc_pkg::DW_DATE +: 5] = t.date;
		w[rtc_pkg::DW_MONTH +: 4] = t.month;
		w[rtc_pkg::DW_YEAR +: 16] = t.year;
		date_word = w;
	endfunction

	logic ack;
	logic rd_go;
	logic wr_go;
	logic [31:0] wmerged;
	logic [31:0] rd_mux;
	logic [2:0] ctrl;
	logic clk_en;
	logic irq_on;
	logic [23:0] tb_acc;
	logic tb_en;
	logic [14:0] frac;
	logic sec_pend;
	logic sec_wrap;
	logic take;
	seq_e state;
	rtc_pkg::time_s rec;
	logic [1:0] status;
	logic [1:0] mask;
	logic [1:0] stat_set;
	logic [1:0] stat_clr;
	logic remote_go;

	// bus: one wait cycle on every access, answer on the second edge
	assign waitrequest_o = (read_i | write_i) & ~ack;
	assign rd_go = read_i & ack;
	assign wr_go = write_i & ack;
	assign clk_en = ctrl[rtc_pkg::CTRL_EN_BIT];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ack <= 1'b0;
		end else begin
			ack <= (read_i | write_i) & ~ack;
		end
	end

	always_comb begin
		wmerged = 32'h00000000;
		unique case (address_i)
			rtc_pkg::OFS_CTRL: wmerged = merge({29'h0, ctrl}, writedata_i, byteenable_i);
			rtc_pkg::OFS_SUBSEC: wmerged = merge({17'h0, frac}, writedata_i, byteenable_i);
			rtc_pkg::OFS_TIME: wmerged = merge(time_word(rec), writedata_i, byteenable_i);
			rtc_pkg::OFS_DATE: wmerged = merge(date_word(rec), writedata_i, byteenable_i);
			rtc_pkg::OFS_MASK: wmerged = merge({30'h0, mask}, writedata_i, byteenable_i);
			default: wmerged = merge(32'h00000000, writedata_i, byteenable_i);
		endcase
	end

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (address_i)
			rtc_pkg::OFS_CTRL: rd_mux = {29'h0, ctrl};
			rtc_pkg::OFS_CMD: rd_mux = {31'h0, ~irq_on};
			rtc_pkg::OFS_SUBSEC: rd_mux = {17'h0, frac};
			rtc_pkg::OFS_TIME: rd_mux = time_word(rec);
			rtc_pkg::OFS_DATE: rd_mux = date_word(rec);
			rtc_pkg::OFS_STATUS: rd_mux = {30'h0, status};
			rtc_pkg::OFS_MASK: rd_mux = {30'h0, mask};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// data captured in the wait cycle, stands through the accepting edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			readdata_o <= 32'h00000000;
		end else if (read_i & ~ack) begin
			readdata_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl <= rtc_pkg::CTRL_RESET;
		end else if (wr_go && address_i == rtc_pkg::OFS_CTRL) begin
			ctrl <= wmerged[2:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mask <= rtc_pkg::IRQ_MASK_RESET;
		end else if (wr_go && address_i == rtc_pkg::OFS_MASK) begin
			mask <= wmerged[1:0];
		end
	end

	// tick interrupt gate; a second elapsed while suspended waits in sec_pend
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_on <= 1'b1;
		end else if (wr_go && address_i == rtc_pkg::OFS_CMD) begin
			if (writedata_i[rtc_pkg::CMD_RESUME_BIT]) begin
				irq_on <= 1'b1;
			end else if (writedata_i[rtc_pkg::CMD_SUSPEND_BIT]) begin
				irq_on <= 1'b0;
			end
		end
	end

	// fractional divider: 32768 enables per 10 000 000 clocks, no drift
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tb_acc <= 24'h000000;
			tb_en <= 1'b0;
		end else if (!clk_en) begin
			tb_en <= 1'b0;
		end else if (tb_acc + TB_STEP >= TB_WRAP) begin
			tb_acc <= tb_acc + TB_STEP - TB_WRAP;
			tb_en <= 1'b1;
		end else begin
			tb_acc <= tb_acc + TB_STEP;
			tb_en <= 1'b0;
		end
	end

	assign sec_wrap = tb_en && clk_en && (frac == rtc_pkg::FRAC_MAX);

	// software load and clear win over the time-base step
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			frac <= 15'h0000;
		end else if (wr_go && address_i == rtc_pkg::OFS_SUBSEC) begin
			frac <= wmerged[14:0];
		end else if (wr_go && address_i == rtc_pkg::OFS_CMD &&
			writedata_i[rtc_pkg::CMD_CLEAR_BIT]) begin
			frac <= 15'h0000;
		end else if (tb_en && clk_en) begin
			frac <= sec_wrap ? 15'h0000 : frac + 15'h0001;
		end
	end

	assign take = sec_pend && irq_on && clk_en && (state == ST_IDLE);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sec_pend <= 1'b0;
		end else begin
			sec_pend <= sec_wrap | (sec_pend & ~take);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: state <= take ? ST_UPDATE : ST_IDLE;
				ST_UPDATE: state <= ST_SIGNAL;
				ST_SIGNAL: state <= ST_IDLE;
			endcase
		end
	end

	assign remote_go = remote_set_i && ctrl[rtc_pkg::CTRL_LINK_BIT];

	// bus write beats remote load beats the second update
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rec <= rtc_pkg::TIME_RESET;
		end else if (wr_go && address_i == rtc_pkg::OFS_TIME) begin
			rec.sec <= wmerged[rtc_pkg::TW_SEC +: 6];
			rec.min <= wmerged[rtc_pkg::TW_MIN +: 6];
			rec.hour <= wmerged[rtc_pkg::TW_HOUR +: 5];
			rec.dow <= wmerged[rtc_pkg::TW_DOW +: 3];
		end else if (wr_go && address_i == rtc_pkg::OFS_DATE) begin
			rec.date <= wmerged[rtc_pkg::DW_DATE +: 5];
			rec.month <= wmerged[rtc_pkg::DW_MONTH +: 4];
			rec.year <= wmerged[rtc_pkg::DW_YEAR +: 16];
		end else if (remote_go) begin
			rec <= remote_time_i;
		end else if (state == ST_UPDATE) begin
			rec <= next_time(rec);
		end
	end

	// per-second outputs follow the record update by one cycle
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ping_o <= 1'b0;
			ui_refresh_o <= 1'b0;
			client_push_o <= 1'b0;
			ui_value_o <= rtc_pkg::TIME_RESET;
		end else begin
			ping_o <= (state == ST_SIGNAL);
			ui_refresh_o <= (state == ST_SIGNAL) && ctrl[rtc_pkg::CTRL_LINK_BIT];
			client_push_o <= (state == ST_SIGNAL) && ctrl[rtc_pkg::CTRL_LINK_BIT] &&
				ctrl[rtc_pkg::CTRL_PUSH_BIT];
			if ((state == ST_SIGNAL) && ctrl[rtc_pkg::CTRL_LINK_BIT]) begin
				ui_value_o <= rec;
			end
		end
	end

	// read clears only the bits that were returned, so a late event survives
	always_comb begin
		stat_set = 2'b00;
		stat_set[rtc_pkg::IRQ_TICK_BIT] = (state == ST_SIGNAL);
		stat_set[rtc_pkg::IRQ_REMOTE_BIT] = remote_go;
		stat_clr = 2'b00;
		if (rd_go && address_i == rtc_pkg::OFS_STATUS) begin
			stat_clr = readdata_o[1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			status <= 2'b00;
		end else begin
			status <= (status & ~stat_clr) | stat_set;
		end
	end

	assign irq_o = |(status & mask);

endmodule // second_tick_calendar_clock

// ### tb/second_tick_calendar_clock_assertions.sv
// port-level checker for the second tick calendar clock
`timescale 1ns/10ps
module second_tick_calendar_clock_assertions (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic ping_o,
	input wire logic ui_refresh_o,
	input wire logic client_push_o,
	input wire rtc_pkg::time_s ui_value_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_wait_first: assert property ($rose(read_i | write_i) |-> waitrequest_o)
		else $error("new request answered without a wait cycle");
	a_wait_one: assert property ((read_i | write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("request waited more than one cycle");
	a_idle_ready: assert property (!(read_i | write_i) |-> !waitrequest_o)
		else $error("waitrequest high with no request");
	a_data_cause: assert property ($changed(readdata_o) && !$past(reset_i)
		|-> $past(read_i && waitrequest_o))
		else $error("read data moved outside a read");
	a_ping_gap: assert property (ping_o |=> (!ping_o)[*8])
		else $error("second pulses too close together");
	a_refresh_ping: assert property (ui_refresh_o |-> ping_o)
		else $error("control refresh outside a running second");
	a_push_refresh: assert property (client_push_o |-> ui_refresh_o)
		else $error("client push without control refresh");
	a_value_cause: assert property ($changed(ui_value_o) && !$past(reset_i) |-> ui_refresh_o)
		else $error("control value changed without refresh");
endmodule // second_tick_calendar_clock_assertions

bind second_tick_calendar_clock second_tick_calendar_clock_assertions chk_i (.clk_i(clk_i),
	.reset_i(reset_i), .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o), .ping_o(ping_o), .ui_refresh_o(ui_refresh_o),
	.client_push_o(client_push_o), .ui_value_o(ui_value_o));

// ### tb/ui_client_model.sv
// remote client model: counts per-second traffic and sends time edits
`timescale 1ns/10ps
module ui_client_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ping_i,
	input wire logic refresh_i,
	input wire logic push_i,
	output logic remote_set_o,
	output rtc_pkg::time_s remote_time_o
);
	int pings;
	int refs;
	int pushes;
	initial begin
		remote_set_o = 1'b0;
		remote_time_o = '0;
	end
	always @(posedge clk_i) begin
		pings <= reset_i ? 0 : pings + ping_i;
		refs <= reset_i ? 0 : refs + refresh_i;
		pushes <= reset_i ? 0 : pushes + push_i;
	end
	task send(input rtc_pkg::time_s t);
		@(posedge clk_i);
		remote_set_o <= 1'b1;
		remote_time_o <= t;
		@(posedge clk_i);
		remote_set_o <= 1'b0;
		// edit over, so the old value must not linger on the lines
		remote_time_o <= ~t;
	endtask
endmodule // ui_client_model

// ### tb/second_tick_calendar_clock_tb.sv
// self-checking bench for the second tick calendar clock
`timescale 1ns/10ps
module second_tick_calendar_clock_tb;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [4:0] address_i = 5'h00;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [3:0] byteenable_i = 4'hF;
	logic [31:0] writedata_i = 32'h00000000;
	logic [31:0] readdata_o, q;
	logic waitrequest_o, irq_o, ping_o, ui_refresh_o, client_push_o, remote_set_i;
	rtc_pkg::time_s ui_value_o, remote_time_i;
	int num_errors = 0;
	int comparisons = 0;
	int seed = 32'h7D78;
	int r, y, m, d, w, p0, u0, n;
	int yr[3] = '{2000, 1900, 65535};
	int mo[3] = '{2, 2, 12};
	int dt[3] = '{28, 28, 31};
	int dw[3] = '{6, 7, 3};
	logic [2:0] ctl[3] = '{3'h7, 3'h7, 3'h5};

	always #50 clk_i = ~clk_i;

	second_tick_calendar_clock second_tick_calendar_clock_i (.clk_i(clk_i), .reset_i(reset_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .irq_o(irq_o), .ping_o(ping_o),
		.ui_refresh_o(ui_refresh_o), .client_push_o(client_push_o),
		.ui_value_o(ui_value_o), .remote_set_i(remote_set_i), .remote_time_i(remote_time_i));
	ui_client_model ui_client_model_i (.clk_i(clk_i), .reset_i(reset_i), .ping_i(ping_o),
		.refresh_i(ui_refresh_o), .push_i(client_push_o), .remote_set_o(remote_set_i),
		.remote_time_o(remote_time_i));

	task print_verdict;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// sampled on the rising edge, before the design's own updates of that edge land
	task bus(input logic w, input logic [4:0] a, input logic [31:0] dat);
		n = 0;
		@(posedge clk_i);
		address_i <= a;
		writedata_i <= dat;
		read_i <= !w;
		write_i <= w;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 50);
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			print_verdict;
		end
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(q, e);
	endtask
	function automatic int dim(int mm, int yy);
		if (mm == 2)
			return (yy % 4 == 0 && (yy % 100 != 0 || yy % 400 == 0)) ? 29 : 28;
		return (mm == 4 || mm == 6 || mm == 9 || mm == 11) ? 30 : 31;
	endfunction

	initial begin
		repeat (100000) @(posedge clk_i);
		num_errors++;
		print_verdict;
	end

	initial begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(rtc_pkg::OFS_CTRL, 32'h00000007);
		rd(rtc_pkg::OFS_MASK, 32'h00000000);
		rd(rtc_pkg::OFS_TIME, 32'h07000000);
		rd(rtc_pkg::OFS_DATE, 32'h00000101);
		rd(5'h1C, 32'h00000000);
		$display("test reset values done");
		bus(1'b1, rtc_pkg::OFS_CTRL, 32'h00000000);
		r = $random(seed) & 32'h7FFF;
		bus(1'b1, rtc_pkg::OFS_SUBSEC, r | 32'hFFFF8000);
		rd(rtc_pkg::OFS_SUBSEC, r);
		p0 = ui_client_model_i.pings;
		repeat (1000) @(posedge clk_i);
		rd(rtc_pkg::OFS_SUBSEC, r);
		chk(ui_client_model_i.pings, p0);
		// fraction parked at the wrap point: a running clock would tick within the wait
		bus(1'b1, rtc_pkg::OFS_SUBSEC, 32'h00007FFF);
		repeat (1000) @(posedge clk_i);
		chk(ui_client_model_i.pings, p0);
		rd(rtc_pkg::OFS_STATUS, 32'h00000000);
		rd(rtc_pkg::OFS_SUBSEC, 32'h00007FFF);
		bus(1'b1, rtc_pkg::OFS_CMD, 32'h00000004);
		rd(rtc_pkg::OFS_SUBSEC, 32'h00000000);
		rd(rtc_pkg::OFS_TIME, 32'h07000000);
		$display("test stopped clock and fraction done");
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, rtc_pkg::OFS_CTRL, 32'h00000000);
			bus(1'b1, rtc_pkg::OFS_CMD, 32'h00000001);
			rd(rtc_pkg::OFS_CMD, 32'h00000001);
			bus(1'b1, rtc_pkg::OFS_TIME, dw[i] << 24 | 32'h00173B3B);
			bus(1'b1, rtc_pkg::OFS_DATE, yr[i] << 16 | mo[i] << 8 | dt[i]);
			bus(1'b1, rtc_pkg::OFS_SUBSEC, 32'h00007FFF);
			bus(1'b1, rtc_pkg::OFS_MASK, 32'h00000001);
			bus(1'b1, rtc_pkg::OFS_CMD, 32'h00000002);
			rd(rtc_pkg::OFS_CMD, 32'h00000000);
			p0 = ui_client_model_i.pushes;
			u0 = ui_client_model_i.refs;
			bus(1'b1, rtc_pkg::OFS_CTRL, ctl[i]);
			n = 0;
			while (irq_o !== 1'b1 && n < 3000) begin
				@(posedge clk_i);
				n++;
			end
			if (n >= 3000) begin
				num_errors++;
				print_verdict;
			end
			y = yr[i];
			m = mo[i];
			d = dt[i] + 1;
			w = dw[i] == 7 ? 7 : (dw[i] + 1) % 7;
			if (d > dim(m, y)) begin
				d = 1;
				m++;
				if (m > 12) begin
					m = 1;
					y = (y + 1) % 65536;
				end
			end
			rd(rtc_pkg::OFS_TIME, w << 24);
			rd(rtc_pkg::OFS_DATE, y << 16 | m << 8 | d);
			chk(ui_value_o, {y[15:0], m[3:0], d[4:0], w[2:0], 17'h00000});
			chk(ui_client_model_i.refs - u0, 1);
			chk(ui_client_model_i.pushes - p0, ctl[i][1]);
			rd(rtc_pkg::OFS_STATUS, 32'h00000001);
			rd(rtc_pkg::OFS_STATUS, 32'h00000000);
			chk(irq_o, 0);
			$display("test rollover case %0d done", i);
		end
		ui_client_model_i.send({16'h1234, 4'h5, 5'h11, 3'h2, 5'h09, 6'h1E, 6'h2D});
		repeat (2) @(posedge clk_i);
		rd(rtc_pkg::OFS_TIME, 32'h02091E2D);
		rd(rtc_pkg::OFS_DATE, 32'h12340511);
		chk(irq_o, 0);
		rd(rtc_pkg::OFS_STATUS, 32'h00000002);
		$display("test remote edit done");
		print_verdict;
	end
endmodule // second_tick_calendar_clock_tb
